// ---- rtl/sfcsp_front.sv ----
// serial flash command front end: framing, write latch, id read, status read and write, protection
// Contract
// (R1) 128 KB array, 32 sectors, two blocks
// (R2) unknown command: standby, output off, until select
// (R3) known command stays active until select rises
// (R4) sample rising edge, shift falling, modes 0/3
// (R5) read commands end at once on select
// (R6) no-data commands need whole-byte select rise
// (R7) array access ignored during busy cycle
// (R8) write-unlock sets write latch
// (R9) host unlocks before every modifying command
// (R10) write-lock clears write latch
// (R11) latch cleared at reset and completions
// (R12) id read shifts out 24 bits
// (R13) id read not decoded while busy
// (R14) status read anytime, repeats while selected
// (R15) status byte layout lock,0,0,0,bp,latch,busy
// (R16) busy flag high during self-timed cycle
// (R17) latch clear refuses status write
// (R18) only status write changes protect level
// (R19) lock and guard low reject status writes
// (R20) status write: command, one byte, select high; code also runs it after more whole data bytes, using the last one
// (R21) status write changes lock and protect only
// (R22) write cycle starts at select rise, clears
// (R23) 05h decodes as status read
// (R24) 01h decodes as status write
// (R25) host sends only defined command codes
// (R26) busy and latch zero after reset
module sfcsp_front #(
    parameter int STATUS_WRITE_CYC = sfcsp_pkg::SFCSP_STATUS_WRITE_CYC, // self-timed length in clocks
    parameter logic [23:0] ID_CODE = sfcsp_pkg::SFCSP_ID_DEFAULT // arbitrary value
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic csPin_b,
    input wire logic sclkPin,
    input wire logic mosiPin,
    input wire logic writeGuardPin_b,
    output logic misoData,
    output logic misoEn,
    output sfcsp_pkg::sfcsp_status_t statusOut,
    output logic pinLockedState,
    output logic [4:0] sectorCount
);
    import sfcsp_pkg::*;

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    sfcsp_state_s_t s_r; // whole block state
    sfcsp_state_s_t s_nxt; // next value
    logic selLvl; // synced select, active low
    logic selFall; // select just fell
    logic selRise; // select just rose
    logic sclkRise; // rising serial clock
    logic sclkFall; // falling serial clock
    logic [7:0] byteNow; // byte completed this edge
    logic [7:0] statusByte; // assembled status byte
    logic hwProt; // pin locked state

    // ------------------------------------------------------------
    // status byte and edge detection
    // ------------------------------------------------------------
    always_comb begin
        // layout with fixed zero bits 6..4
        statusByte = {s_r.st.lock, 3'b000, s_r.st.level, s_r.st.latch, s_r.st.busy}; // R15
        hwProt = s_r.st.lock & ~s_r.guardSync[1]; // R19
        // edges only look at second and third sync stages
        selLvl = s_r.csSync[1];
        selFall = s_r.csSync[2] & ~s_r.csSync[1];
        selRise = ~s_r.csSync[2] & s_r.csSync[1];
        sclkRise = ~s_r.clkSync[2] & s_r.clkSync[1] & ~selLvl; // R4
        sclkFall = s_r.clkSync[2] & ~s_r.clkSync[1] & ~selLvl; // R4
        byteNow = {s_r.shiftIn[6:0], s_r.mosiSync[1]};
    end

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.csSync = {s_r.csSync[1:0], csPin_b};
        s_nxt.clkSync = {s_r.clkSync[1:0], sclkPin};
        s_nxt.mosiSync = {s_r.mosiSync[0], mosiPin};
        s_nxt.guardSync = {s_r.guardSync[0], writeGuardPin_b};
        s_nxt.byteDone = s_r.byteDone;

        // self-timed status write cycle
        if (s_r.st.busy) begin
            if (s_r.busyCnt == 32'h0000_0001) begin
                s_nxt.st.busy = 1'b0; // R16
                s_nxt.st.latch = 1'b0; // R11 R22
                s_nxt.busyCnt = 32'h0000_0000;
            end else begin
                s_nxt.busyCnt = s_r.busyCnt - 32'h0000_0001;
            end
        end

        // input bit counting on rising serial clock
        if (sclkRise) begin
            s_nxt.shiftIn = byteNow;
            s_nxt.bitCnt = s_r.bitCnt + 3'h1;
            s_nxt.byteDone = (s_r.bitCnt == SFCSP_BIT_LAST); // R6
        end

        case (s_r.state)
            SFCSP_IDLE: begin
                // wait for a select fall to frame a command
                if (selFall) begin
                    s_nxt.state = SFCSP_CMD;
                    s_nxt.bitCnt = 3'h0;
                    s_nxt.byteDone = 1'b0;
                end
            end
            SFCSP_CMD: begin
                if (selRise) begin
                    s_nxt.state = SFCSP_IDLE; // partial byte: nothing happens
                end else if (sclkRise && s_r.bitCnt == SFCSP_BIT_LAST) begin
                    s_nxt.cmd = byteNow;
                    if (byteNow == SFCSP_STATUS_READ_CMD) begin // R23 R14
                        s_nxt.state = SFCSP_OUT;
                        s_nxt.shiftOut = {statusByte, 16'h0000};
                    end else if (byteNow == SFCSP_ID_READ_CMD && !s_r.st.busy) begin // R13 R7
                        s_nxt.state = SFCSP_OUT;
                        s_nxt.shiftOut = ID_CODE;
                        s_nxt.outCnt = 5'(SFCSP_ID_BITS);
                    end else if (byteNow == SFCSP_STATUS_WRITE_CMD) begin // R24
                        s_nxt.state = SFCSP_ARG;
                    end else if (byteNow == SFCSP_WRITE_UNLOCK_CMD || byteNow == SFCSP_WRITE_LOCK_CMD) begin
                        s_nxt.state = SFCSP_HOLDACT; // R3
                    end else begin
                        s_nxt.state = SFCSP_STBY; // R2
                    end
                end
            end
            SFCSP_ARG: begin
                // status write data byte; executes only on exact byte boundary
                if (selRise) begin
                    s_nxt.state = SFCSP_IDLE;
                    if (s_r.byteDone && s_r.bitCnt == 3'h0 && s_r.st.latch && !s_r.st.busy && !hwProt) begin // R6 R17 R19 R20
                        s_nxt.st.lock = s_r.shiftIn[SFCSP_ST_LOCK]; // R21 R18
                        s_nxt.st.level = {s_r.shiftIn[SFCSP_ST_BP_HI], s_r.shiftIn[SFCSP_ST_BP_LO]}; // R21 R18
                        s_nxt.st.busy = 1'b1; // R22 R16
                        s_nxt.busyCnt = 32'(STATUS_WRITE_CYC);
                    end
                end else if (sclkRise && s_r.bitCnt == SFCSP_BIT_LAST && s_r.byteDone) begin
                    s_nxt.byteDone = 1'b0; // never reached: byteDone is already clear by the eighth rise, so extra data bytes are still taken
                end
            end
            SFCSP_OUT: begin
                // shift on falling clock; select rise ends at once
                if (selRise) begin
                    s_nxt.state = SFCSP_IDLE; // R5
                    s_nxt.soEn = 1'b0;
                end else if (sclkFall) begin
                    s_nxt.soEn = 1'b1;
                    if (s_r.cmd == SFCSP_STATUS_READ_CMD) begin
                        // status repeats; live value reloaded each byte
                        s_nxt.soData = s_r.shiftOut[23];
                        s_nxt.shiftOut = {s_r.shiftOut[22:0], 1'b0};
                        if (s_r.bitCnt == 3'h0 && s_r.byteDone) begin
                            s_nxt.soData = statusByte[7]; // R14
                            s_nxt.shiftOut = {statusByte[6:0], 17'h00000};
                        end
                    end else if (s_r.outCnt != 5'h00) begin
                        s_nxt.soData = s_r.shiftOut[23]; // R12
                        s_nxt.shiftOut = {s_r.shiftOut[22:0], 1'b0};
                        s_nxt.outCnt = s_r.outCnt - 5'h01;
                    end else begin
                        s_nxt.soData = 1'b0; // past 24 bits: drive zero
                    end
                end
            end
            SFCSP_HOLDACT: begin
                // one-byte commands act only on a clean select rise
                if (selRise) begin
                    s_nxt.state = SFCSP_IDLE;
                    // ignored while busy, so a completion clear in the same cycle is kept
                    if (s_r.byteDone && s_r.bitCnt == 3'h0 && !s_r.st.busy) begin // R6 R7
                        if (s_r.cmd == SFCSP_WRITE_UNLOCK_CMD) begin
                            s_nxt.st.latch = 1'b1; // R8
                        end else begin
                            s_nxt.st.latch = 1'b0; // R10 R11
                        end
                    end
                end
            end
            default: begin
                // standby: output off, wait for a fresh select fall
                s_nxt.soEn = 1'b0; // R2
                if (selFall) begin
                    s_nxt.state = SFCSP_CMD;
                    s_nxt.bitCnt = 3'h0;
                    s_nxt.byteDone = 1'b0;
                end
            end
        endcase
        if (selLvl) begin
            s_nxt.soEn = 1'b0; // output off whenever deselected
        end
    end

    // ------------------------------------------------------------
    // state register, synchronous reset
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_r <= '{csSync: 3'h7, clkSync: 3'h0, mosiSync: 2'h0, guardSync: 2'h3, state: SFCSP_IDLE,
                     cmd: 8'h00, shiftIn: 8'h00, bitCnt: 3'h0, byteDone: 1'b0, shiftOut: 24'h000000,
                     outCnt: 5'h00, soData: 1'b0, soEn: 1'b0, st: SFCSP_STATUS_RESET[4:0], // R26 R11
                     busyCnt: 32'h0000_0000};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs from flops, except pinLockedState (a gate on two flops) and the constant sectorCount
    // ------------------------------------------------------------
    assign misoData = s_r.soData;
    assign misoEn = s_r.soEn;
    assign statusOut = s_r.st;
    assign pinLockedState = s_r.st.lock & ~s_r.guardSync[1];
    // sector count from the map, cut to five bits, so the 32 sectors read as zero
    assign sectorCount = 5'((SFCSP_ADDR_TOP + 24'h000001) >> SFCSP_SECTOR_LSB) - 5'h00; // R1
endmodule

// ---- rtl/sfcsp_pkg.sv ----
// package: command codes, status layout, timing and state types for the flash command front end
package sfcsp_pkg;
    // ------------------------------------------------------------
    // memory map
    // ------------------------------------------------------------
    localparam logic [23:0] SFCSP_ADDR_TOP = 24'h01FFFF; // last array byte
    localparam logic [23:0] SFCSP_SECTOR_SIZE = 24'h001000; // 4 KB sector
    localparam logic [23:0] SFCSP_BLOCK_SIZE = 24'h010000; // 64 KB block
    localparam int SFCSP_SECTOR_LSB = 12; // sector number starts here
    localparam int SFCSP_BLOCK_LSB = 16; // block number bit
    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [7:0] SFCSP_WRITE_UNLOCK_CMD = 8'h06;
    localparam logic [7:0] SFCSP_WRITE_LOCK_CMD = 8'h04;
    localparam logic [7:0] SFCSP_ID_READ_CMD = 8'h9F;
    localparam logic [7:0] SFCSP_STATUS_READ_CMD = 8'h05;
    localparam logic [7:0] SFCSP_STATUS_WRITE_CMD = 8'h01;
    // ------------------------------------------------------------
    // status byte fields and reset
    // ------------------------------------------------------------
    localparam int SFCSP_ST_LOCK = 7; // status lock bit
    localparam int SFCSP_ST_BP_HI = 3; // protect level high
    localparam int SFCSP_ST_BP_LO = 2; // protect level low
    localparam int SFCSP_ST_LATCH = 1; // write latch
    localparam int SFCSP_ST_BUSY = 0; // busy flag
    localparam logic [7:0] SFCSP_STATUS_RESET = 8'h00;
    localparam logic [7:0] SFCSP_STATUS_WMASK = 8'h8C; // bits a status write may change
    // ------------------------------------------------------------
    // identification and counts
    // ------------------------------------------------------------
    localparam logic [23:0] SFCSP_ID_DEFAULT = 24'hA51234; // arbitrary value, not a real part code
    localparam int SFCSP_ID_BITS = 24;
    localparam logic [2:0] SFCSP_BIT_LAST = 3'h7;
    // ------------------------------------------------------------
    // timing: status write self-timed cycle
    // ------------------------------------------------------------
    localparam int SFCSP_CLK_MHZ = 100;
    localparam int SFCSP_STATUS_WRITE_TIME_US = 10; // chosen default duration
    localparam int SFCSP_STATUS_WRITE_CYC = SFCSP_STATUS_WRITE_TIME_US * SFCSP_CLK_MHZ;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SFCSP_IDLE = 3'b000, // waiting for select
        SFCSP_CMD = 3'b001, // shifting command byte
        SFCSP_ARG = 3'b011, // shifting status data byte
        SFCSP_OUT = 3'b010, // shifting read data out
        SFCSP_HOLDACT = 3'b110, // recognised, no-data command waiting for select rise
        SFCSP_STBY = 3'b100 // ignoring bus until next select fall
    } sfcsp_state_t;

    typedef struct packed {
        logic lock; // status lock bit
        logic [1:0] level; // protect level hi/lo
        logic latch; // write latch
        logic busy; // busy flag
    } sfcsp_status_t;

    typedef struct packed {
        logic [2:0] csSync; // select sync, [0] first stage
        logic [2:0] clkSync; // serial clock sync
        logic [1:0] mosiSync; // serial in sync
        logic [1:0] guardSync; // write-guard pin sync
        sfcsp_state_t state;
        logic [7:0] cmd; // command code in flight
        logic [7:0] shiftIn; // input shift register
        logic [2:0] bitCnt; // bits received of current byte
        logic byteDone; // a whole byte ended on last rising edge
        logic [23:0] shiftOut; // output data
        logic [4:0] outCnt; // id bits left
        logic soData; // serial out level
        logic soEn; // serial out enable
        sfcsp_status_t st;
        logic [31:0] busyCnt; // self-timed cycle counter
    } sfcsp_state_s_t;
endpackage

// ---- sim/sfcsp_front_test.sv ----
// testbench: latch, status, id and protection scenarios for the command front end
module sfcsp_front_test;
    timeunit 1ns;
    timeprecision 100ps;
    import sfcsp_pkg::*;
    localparam int SWC = 1000; // write cycle clocks
    localparam logic [23:0] ID = 24'h5AC3E1; // arbitrary identity value
    logic clk, rst_b, csPin_b, sclkPin, mosiPin, writeGuardPin_b, misoData, misoEn, pinLockedState, rxValid;
    sfcsp_status_t statusOut;
    logic [4:0] sectorCount;
    logic [31:0] rxWord;
    logic [63:0] expQ[$]; // {care mask, expected} per frame
    int bad_count = 0, num_checks = 0, seed = 32'h3635, enCnt = 0;
    logic lk = 1'b0, lt = 1'b0; // model of lock and latch
    logic [1:0] lv = 2'h0; // model of protect level
    sfcsp_front #(.STATUS_WRITE_CYC(SWC), .ID_CODE(ID)) dut_u (.clk(clk), .rst_b(rst_b), .csPin_b(csPin_b),
        .sclkPin(sclkPin), .mosiPin(mosiPin), .writeGuardPin_b(writeGuardPin_b), .misoData(misoData),
        .misoEn(misoEn), .statusOut(statusOut), .pinLockedState(pinLockedState), .sectorCount(sectorCount));
    sfcsp_host host_u (.clk(clk), .csPin_b(csPin_b), .sclkPin(sclkPin), .mosiPin(mosiPin),
        .misoData(misoData), .misoEn(misoEn), .rxWord(rxWord), .rxValid(rxValid));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic frame(input logic [31:0] txd, input int n, input logic [31:0] exp, input logic [31:0] mask);
        logic [31:0] rxd;
        expQ.push_back({mask, exp});
        host_u.xfer(txd, n, 1'($random(seed)), rxd);
    endtask
    task automatic rdst(input logic bz);
        frame(32'h0500, 16, {24'h0, lk, 3'h0, lv, lt, bz}, 32'hFF);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // output watcher: oldest note against each finished frame
    always @(posedge clk) begin
        logic [63:0] e;
        if (misoEn === 1'b1) enCnt++;
        if (rxValid === 1'b1) begin
            e = expQ.pop_front();
            if (e[63:32] != 32'h0) check(rxWord & e[63:32], e[31:0]);
        end
    end
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        finish_test();
    end
    initial begin
        logic [7:0] d;
        logic acc;
        int e0;
        rst_b = 1'b0;
        writeGuardPin_b = 1'b1;
        repeat (6) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check(32'(statusOut), 32'h0);
        check(32'(sectorCount), 32'h0);
        rdst(1'b0);
        frame(32'h06, 8, 32'h0, 32'h0);
        lt = 1'b1; // unlock sets the latch
        rdst(1'b0);
        frame(32'h04, 8, 32'h0, 32'h0);
        lt = 1'b0; // lock clears it
        rdst(1'b0);
        frame(32'h06, 7, 32'h0, 32'h0);
        frame(32'h018C, 16, 32'h0, 32'h0);
        rdst(1'b0);
        $display("test latch done");
        for (int k = 0; k < 6; k++) begin
            writeGuardPin_b = 1'($random(seed));
            d = 8'($random(seed));
            frame(32'h06, 8, 32'h0, 32'h0);
            lt = 1'b1;
            acc = !(lk && !writeGuardPin_b); // refused when pin locked
            // protect bits take the new value as the self-timed cycle starts
            if (acc) {lk, lv} = {d[7], d[3:2]};
            frame({16'h0, 8'h01, d}, 16, 32'h0, 32'h0);
            rdst(acc);
            e0 = enCnt;
            if (acc) frame(32'h9F00, 16, 32'h0, 32'h0); // id read while busy
            check(32'(enCnt), 32'(e0));
            repeat (SWC + 10) @(posedge clk);
            if (acc) lt = 1'b0;
            rdst(1'b0);
        end
        $display("test status write done");
        frame(32'h9F000000, 32, {8'h00, ID}, 32'h00FFFFFF);
        frame(32'h09F0, 12, {28'h0, ID[23:20]}, 32'hF);
        e0 = enCnt;
        frame(32'hFF00, 16, 32'h0, 32'h0);
        check(32'(enCnt), 32'(e0));
        rdst(1'b0);
        $display("test id and unknown done");
        repeat (20) @(posedge clk);
        finish_test();
    end
endmodule

// ---- sim/sfcsp_host.sv ----
// host model: drives select, serial clock and data in, collects data out
module sfcsp_host (
    input wire logic clk,
    output logic csPin_b,
    output logic sclkPin,
    output logic mosiPin,
    input wire logic misoData,
    input wire logic misoEn,
    output logic [31:0] rxWord,
    output logic rxValid
);
    timeunit 1ns;
    timeprecision 100ps;
    logic soLast = 1'b0; // last level the device drove
    // a released line shows the inverse, so stale data never passes
    wire logic soWire = misoEn ? misoData : ~soLast;
    initial begin
        csPin_b = 1'b1;
        sclkPin = 1'b0;
        mosiPin = 1'b0;
        rxWord = 32'h0;
        rxValid = 1'b0;
    end
    always @(posedge clk) begin
        if (misoEn) begin
            soLast <= misoData;
        end
    end
    // half a serial period of 160 ns, pins move just after the edge
    task automatic half();
        repeat (8) @(posedge clk);
        #1;
    endtask
    // one frame of n bits, MSB first, mode 3 when m3 is set
    task automatic xfer(input logic [31:0] txd, input int n, input logic m3, output logic [31:0] rxd);
        rxd = 32'h0;
        sclkPin = m3; // idle level chosen while deselected
        half();
        csPin_b = 1'b0;
        half();
        for (int i = n - 1; i >= 0; i--) begin
            sclkPin = 1'b0; // falling edge, device shifts out
            mosiPin = txd[i];
            half();
            sclkPin = 1'b1; // rising edge, both sides sample
            rxd = {rxd[30:0], soWire};
            half();
        end
        sclkPin = m3;
        half();
        csPin_b = 1'b1;
        mosiPin = ~mosiPin; // released input line
        rxWord = rxd;
        rxValid = 1'b1; // one clock only, so the watcher pops once
        @(posedge clk);
        #1;
        rxValid = 1'b0;
        half();
    endtask
endmodule

// ---- sim/sfcsp_monitor.sv ----
// checker: port timing and protection properties of the command front end
module sfcsp_monitor #(
    parameter int STATUS_WRITE_CYC = 1000 // self-timed length in clocks
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic csPin_b,
    input wire logic sclkPin,
    input wire logic mosiPin,
    input wire logic writeGuardPin_b,
    input wire logic misoData,
    input wire logic misoEn,
    input wire sfcsp_pkg::sfcsp_status_t statusOut,
    input wire logic pinLockedState,
    input wire logic [4:0] sectorCount
);
    timeunit 1ns;
    timeprecision 100ps;
    import sfcsp_pkg::*;
    logic [31:0] busyRun_r; // clocks the busy flag has stood high
    logic [31:0] busyRun_nxt; // next run length
    // a counter, because a long repetition would be unrolled by the tools
    always_comb begin
        busyRun_nxt = statusOut.busy ? busyRun_r + 32'h1 : 32'h0;
    end
    always_ff @(posedge clk) begin
        busyRun_r <= rst_b ? busyRun_nxt : 32'h0;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    reset_clear_a: assert property (rst_b && !$past(rst_b) |-> statusOut == 5'h00 && !misoEn)
        else $error("status or output not clear after reset");
    idle_quiet_a: assert property (csPin_b [*6] |-> !misoEn)
        else $error("output driven while deselected");
    out_in_frame_a: assert property ($rose(misoEn) |-> !csPin_b)
        else $error("output enabled outside a frame");
    busy_start_a: assert property ($rose(statusOut.busy) |-> csPin_b && $past(statusOut.latch))
        else $error("write cycle began without latch or select rise");
    busy_length_a: assert property ($fell(statusOut.busy) |-> busyRun_r == STATUS_WRITE_CYC)
        else $error("write cycle length wrong");
    busy_end_a: assert property ($fell(statusOut.busy) |-> !statusOut.latch)
        else $error("latch still set after write cycle");
    protect_change_a: assert property (!$stable({statusOut.lock, statusOut.level}) |-> $rose(statusOut.busy))
        else $error("protect bits changed outside write start");
    locked_map_a: assert property (writeGuardPin_b == $past(writeGuardPin_b, 3) && $stable(writeGuardPin_b)
        |-> pinLockedState == (statusOut.lock && !writeGuardPin_b)) else $error("locked state wrong");
    locked_refuse_a: assert property (pinLockedState |=> !$rose(statusOut.busy))
        else $error("status write ran while pin locked");
    latch_set_a: assert property ($rose(statusOut.latch) |-> csPin_b && !statusOut.busy)
        else $error("latch set mid frame or while busy");
    latch_clear_a: assert property ($fell(statusOut.latch) |-> csPin_b || $fell(statusOut.busy))
        else $error("latch cleared without cause");
endmodule

bind sfcsp_front sfcsp_monitor #(.STATUS_WRITE_CYC(STATUS_WRITE_CYC)) mon_u (.clk(clk), .rst_b(rst_b),
    .csPin_b(csPin_b), .sclkPin(sclkPin), .mosiPin(mosiPin), .writeGuardPin_b(writeGuardPin_b),
    .misoData(misoData), .misoEn(misoEn), .statusOut(statusOut), .pinLockedState(pinLockedState),
    .sectorCount(sectorCount));
